//--- design/can_dispatch_timer_filter_status.sv
// Dispatch timer registers overlaid on the low filter match status byte.
// Assumes synchronous byte register strobes and a one-cycle filter match pulse.
`timescale 1ns/1ps
`default_nettype none
module can_dispatch_timer_filter_status #(
   parameter int STEP_CYCLES = dispatch_pkg::STEP_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_silent,
   input wire logic [11:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_filter_hit,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_dispatch_req,
   output logic o_dispatch_on
);
   typedef struct packed {
      logic [3:0] guard;
      logic [27:0] period;
      logic [7:0] match;
      logic [27:0] ticks;
      logic [7:0] rdata;
      logic rvalid;
      logic req;
      logic on;
   } top_state_t;
   top_state_t state;
   top_state_t next_state;
   logic step_tick;
   logic unlocked;
   logic [7:0] rd_mux;

   step_divider #(
      .CYCLES(STEP_CYCLES)
   ) u_step (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_run(state.on & ~i_silent),
      .o_tick(step_tick)
   );

   always_comb begin
      unlocked = ({state.guard[3], state.guard[1], state.guard[0]} == dispatch_pkg::GUARD_UNLOCK);
      rd_mux = 8'h00;
      if (i_silent) begin
         if (i_addr == dispatch_pkg::ADDR_TOP_GUARD) begin
            rd_mux = {state.guard, state.period[27:24]};
         end else if (i_addr == dispatch_pkg::ADDR_BYTE2) begin
            rd_mux = state.period[23:16];
         end else if (i_addr == dispatch_pkg::ADDR_BYTE1) begin
            rd_mux = state.period[15:8];
         end else if (i_addr == dispatch_pkg::ADDR_BYTE0) begin
            rd_mux = state.period[7:0];
         end
      end else if (i_addr == dispatch_pkg::ADDR_BYTE0) begin
         rd_mux = state.match;
      end
   end

   always_comb begin
      next_state = state;
      next_state.req = 1'b0;
      next_state.rvalid = i_rd;
      next_state.rdata = i_rd ? rd_mux : 8'h00;
      if (i_wr && i_silent) begin
         if (i_addr == dispatch_pkg::ADDR_TOP_GUARD) begin
            next_state.guard = i_wdata[7:dispatch_pkg::GUARD_POS];
            next_state.period[27:24] = i_wdata[3:0];
         end else if (i_addr == dispatch_pkg::ADDR_BYTE2 && unlocked) begin
            next_state.period[23:16] = i_wdata;
         end else if (i_addr == dispatch_pkg::ADDR_BYTE1 && unlocked) begin
            next_state.period[15:8] = i_wdata;
         end else if (i_addr == dispatch_pkg::ADDR_BYTE0 && unlocked) begin
            next_state.period[7:0] = i_wdata;
         end
      end
      next_state.match = state.match | i_filter_hit;
      next_state.on = (next_state.period != dispatch_pkg::PERIOD_RESET);
      if (!state.on || i_silent) begin
         next_state.ticks = 28'h0000000;
      end else if (step_tick) begin
         if (state.ticks + 28'h0000001 >= state.period) begin
            next_state.ticks = 28'h0000000;
            next_state.req = 1'b1;
         end else begin
            next_state.ticks = state.ticks + 28'h0000001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state.guard <= dispatch_pkg::GUARD_RESET;
         state.period <= dispatch_pkg::PERIOD_RESET;
         state.match <= dispatch_pkg::MATCH_RESET;
         state.ticks <= 28'h0000000;
         state.rdata <= dispatch_pkg::RESET_BYTE;
         state.rvalid <= 1'b0;
         state.req <= 1'b0;
         state.on <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign o_rdata = state.rdata;
   assign o_rvalid = state.rvalid;
   assign o_dispatch_req = state.req;
   assign o_dispatch_on = state.on;

   a_match_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ($past(i_filter_hit) & ~state.match) == 8'h00)
      else $error("Filter hit not recorded");
   a_op_no_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && !i_silent) |=> ($stable(state.period) && $stable(state.guard)))
      else $error("Operating mode write changed dispatch state");
   a_lock_byte0: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && !unlocked && i_addr != dispatch_pkg::ADDR_TOP_GUARD) |=> $stable(state.period))
      else $error("Locked lower byte accepted a write");
   a_byte0_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE0) |=> state.period[7:0] == $past(i_wdata))
      else $error("Unlocked byte 0 write lost");
   a_top_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && i_addr == dispatch_pkg::ADDR_TOP_GUARD) |=> {state.guard, state.period[27:24]} == $past(i_wdata))
      else $error("Top byte write lost");
   a_op_read_match: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && !i_silent && i_addr == dispatch_pkg::ADDR_BYTE0) |=> o_rvalid && o_rdata == $past(state.match))
      else $error("Operating read of match byte wrong");
   a_silent_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && i_silent && i_addr == dispatch_pkg::ADDR_BYTE0) |=> o_rdata == $past(state.period[7:0]))
      else $error("Silent read did not return dispatch byte 0");
   a_zero_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state.period == 28'h0000000) |-> ##1 !o_dispatch_req)
      else $error("Dispatch request with zero period");
   a_req_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_dispatch_req |-> $past(step_tick) && $past(state.on))
      else $error("Dispatch request without step tick");

   a_rvalid_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd
      |=> o_rvalid)
      else $error("Read strobe gave no valid pulse");

   a_rvalid_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_rvalid
      |-> $past(i_rd))
      else $error("Valid pulse without read strobe");

   a_idle_rdata: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !i_rd
      |=> o_rdata == 8'h00 && !o_rvalid)
      else $error("Read data not cleared between reads");

   a_op_read_upper: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && !i_silent && i_addr != dispatch_pkg::ADDR_BYTE0)
      |=> o_rdata == 8'h00)
      else $error("Operating read outside match byte not zero");

   a_top_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && i_silent && i_addr == dispatch_pkg::ADDR_TOP_GUARD)
      |=> o_rdata == $past({state.guard, state.period[27:24]}))
      else $error("Top byte read wrong");

   a_byte2_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && i_silent && i_addr == dispatch_pkg::ADDR_BYTE2)
      |=> o_rdata == $past(state.period[23:16]))
      else $error("Byte 2 read wrong");

   a_byte1_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && i_silent && i_addr == dispatch_pkg::ADDR_BYTE1)
      |=> o_rdata == $past(state.period[15:8]))
      else $error("Byte 1 read wrong");

   a_silent_unmapped: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_rd && i_silent && (i_addr < dispatch_pkg::ADDR_TOP_GUARD || i_addr > dispatch_pkg::ADDR_BYTE0))
      |=> o_rdata == 8'h00)
      else $error("Unmapped silent read not zero");

   a_match_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state.match & $past(state.match))
      == $past(state.match))
      else $error("Match bit cleared without reset");

   a_match_only_hit: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state.match & ~$past(state.match) & ~$past(i_filter_hit))
      == 8'h00)
      else $error("Match bit set without filter hit");

   a_match_no_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && !i_silent)
      |=> state.match == ($past(state.match) | $past(i_filter_hit)))
      else $error("Operating write changed match bits");

   a_byte2_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE2)
      |=> state.period[23:16] == $past(i_wdata))
      else $error("Unlocked byte 2 write lost");

   a_byte1_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE1)
      |=> state.period[15:8] == $past(i_wdata))
      else $error("Unlocked byte 1 write lost");

   a_byte2_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE2)
      |=> $stable(state.guard) && $stable(state.period[27:24]) && $stable(state.period[15:0]))
      else $error("Byte 2 write disturbed other bits");

   a_byte1_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE1)
      |=> $stable(state.guard) && $stable(state.period[27:16]) && $stable(state.period[7:0]))
      else $error("Byte 1 write disturbed other bits");

   a_byte0_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE0)
      |=> $stable(state.guard) && $stable(state.period[27:8]))
      else $error("Byte 0 write disturbed other bits");

   a_top_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && i_addr == dispatch_pkg::ADDR_TOP_GUARD)
      |=> $stable(state.period[23:0]))
      else $error("Top byte write disturbed lower bytes");

   a_guard_silent: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(i_wr && i_silent && i_addr == dispatch_pkg::ADDR_TOP_GUARD)
      |=> $stable(state.guard))
      else $error("Guard bits changed outside silent top write");

   a_period_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(i_wr && i_silent)
      |=> $stable(state.period))
      else $error("Period changed outside silent write");

   a_on_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_dispatch_on
      == (state.period != 28'h0000000))
      else $error("Dispatch enable disagrees with period");

   a_req_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_dispatch_req
      |=> !o_dispatch_req)
      else $error("Dispatch request lasted more than one cycle");

   a_silent_no_req: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_silent
      |=> !o_dispatch_req)
      else $error("Dispatch request in silent mode");

   a_ticks_below: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state.on
      |-> state.ticks < state.period)
      else $error("Period counter passed programmed value");

   a_ticks_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_silent || !state.on)
      |=> state.ticks == 28'h0000000)
      else $error("Period counter not held cleared");

   a_req_at_value: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (step_tick && state.on && !i_silent && state.ticks == state.period - 28'h0000001)
      |=> o_dispatch_req && state.ticks == 28'h0000000)
      else $error("No request or restart at programmed value");

   a_tick_advance: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (step_tick && state.on && !i_silent && state.ticks != state.period - 28'h0000001)
      |=> state.ticks == $past(state.ticks) + 28'h0000001 && !o_dispatch_req)
      else $error("Period counter did not advance on step");

   a_ticks_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!step_tick && state.on && !i_silent)
      |=> $stable(state.ticks))
      else $error("Period counter moved without step");

   a_step_halt: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_silent || !state.on)
      |=> !step_tick)
      else $error("Step tick while dispatch idle");

   a_step_run: assert property (@(posedge i_clk) disable iff (!i_resetn)
      step_tick
      |-> $past(state.on) && !$past(i_silent))
      else $error("Step tick without running dispatch");

   a_on_after_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && unlocked && i_addr == dispatch_pkg::ADDR_BYTE0 && i_wdata != 8'h00)
      |=> o_dispatch_on)
      else $error("Nonzero period left dispatch off");

   a_zero_write_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_silent && i_addr == dispatch_pkg::ADDR_TOP_GUARD && i_wdata[3:0] == 4'h0 && state.period[23:0] == 24'h000000)
      |=> !o_dispatch_on)
      else $error("Zero period left dispatch on");
endmodule
`default_nettype wire

//--- design/dispatch_pkg.sv
// Constants for the dispatch timer and low filter status block.
// Assumes a 250 MHz controller clock and a byte-wide register port.
package dispatch_pkg;
   localparam logic [11:0] ADDR_TOP_GUARD = 12'hB24;
   localparam logic [11:0] ADDR_BYTE2 = 12'hB25;
   localparam logic [11:0] ADDR_BYTE1 = 12'hB26;
   localparam logic [11:0] ADDR_BYTE0 = 12'hB27;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] GUARD_RESET = 4'h0;
   localparam logic [27:0] PERIOD_RESET = 28'h0000000;
   localparam logic [7:0] MATCH_RESET = 8'h00;
   localparam logic [2:0] GUARD_UNLOCK = 3'h6;
   localparam int GUARD_POS = 4;
   localparam int PERIOD_W = 28;
   localparam int STEP_US = 200;
   localparam int CLK_MHZ = 250;
   localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
endpackage

//--- design/step_divider.sv
// Step divider: one-cycle tick every CYCLES clocks.
// Assumes a single synchronous clock domain.
`timescale 1ns/1ps
`default_nettype none
module step_divider #(
   parameter int CYCLES = 50000
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_run,
   output logic o_tick
);
   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } div_state_t;
   div_state_t state;
   div_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (!i_run) begin
         next_state.count = 32'h00000000;
      end else if (state.count == 32'(CYCLES - 1)) begin
         next_state.count = 32'h00000000;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 32'h00000001;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_tick = state.tick;

   a_tick_spacing: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_tick |=> !o_tick)
      else $error("Step tick lasted more than one cycle");
endmodule
`default_nettype wire

//--- bench/can_node_model.sv
// Far-side CAN node: pulses filter hits, times dispatch requests.
// Assumes the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
   input wire logic i_clk,
   input wire logic i_dispatch_req,
   output logic [7:0] o_filter_hit
);
   int req_count = 0;
   int last_gap = 0;
   int since = 0;
   initial o_filter_hit = 8'h00;
   // Cycles between the last two status frames
   always @(posedge i_clk) begin
      since <= since + 1;
      if (i_dispatch_req === 1'b1) begin
         req_count <= req_count + 1;
         last_gap <= since + 1;
         since <= 0;
      end
   end
   // One accepted frame: hit held one cycle
   task automatic accept(input logic [7:0] mask);
      @(posedge i_clk);
      o_filter_hit <= mask;
      @(posedge i_clk);
      o_filter_hit <= 8'h00;
   endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the dispatch timer and low filter status block.
// Assumes a shortened step of 4 clocks and the partner node model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [11:0] ra3 = dispatch_pkg::ADDR_TOP_GUARD;
   localparam logic [11:0] ra2 = dispatch_pkg::ADDR_BYTE2;
   localparam logic [11:0] ra1 = dispatch_pkg::ADDR_BYTE1;
   localparam logic [11:0] ra0 = dispatch_pkg::ADDR_BYTE0;
   logic clk = 1'b0, resetn = 1'b0, silent = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00, hit, rdata;
   logic rvalid, req, on;
   int err_count = 0, check_count = 0, cycles = 0;
   always #2 clk = ~clk;
   can_dispatch_timer_filter_status #(.STEP_CYCLES(4)) dut (.i_clk(clk), .i_resetn(resetn),
      .i_silent(silent), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
      .i_filter_hit(hit), .o_rdata(rdata), .o_rvalid(rvalid), .o_dispatch_req(req), .o_dispatch_on(on));
   can_node_model node (.i_clk(clk), .i_dispatch_req(req), .o_filter_hit(hit));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic wrb(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdb(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rvalid", 1, {31'd0, rvalid});
      chk("rdata", {24'd0, e}, {24'd0, rdata});
   endtask
   task automatic t_reset();
      for (int i = 0; i < 4; i++) rdb(ra3 + 12'(i), 8'h00);
      rdb(ra0 + 12'h001, 8'h00);
      chk("dispatch_on", 0, {31'd0, on});
   endtask
   task automatic t_locked();
      @(posedge clk) silent <= 1'b0;
      wrb(ra3, 8'hF3);
      wrb(ra0, 8'h11);
      @(posedge clk) silent <= 1'b1;
      rdb(ra3, 8'h00);
      rdb(ra0, 8'h00);
      wrb(ra3, 8'h70);
      wrb(ra2, 8'hAA);
      rdb(ra2, 8'h00);
      rdb(ra3, 8'h70);
   endtask
   task automatic t_program();
      wrb(ra3, 8'hA7);
      wrb(ra2, 8'h12);
      wrb(ra1, 8'h34);
      wrb(ra0, 8'h56);
      rdb(ra3, 8'hA7);
      rdb(ra2, 8'h12);
      rdb(ra1, 8'h34);
      rdb(ra0, 8'h56);
      chk("dispatch_on", 1, {31'd0, on});
      wrb(ra3, 8'hA0);
      wrb(ra2, 8'h00);
      wrb(ra1, 8'h00);
      wrb(ra0, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("dispatch_on", 0, {31'd0, on});
   endtask
   task automatic t_dispatch();
      wrb(ra0, 8'h03);
      @(posedge clk) silent <= 1'b0;
      for (int i = 0; i < 200 && node.req_count < 3; i++) @(posedge clk);
      #1;
      chk("gap", 12, node.last_gap);
      chk("frames", 3, node.req_count);
   endtask
   task automatic t_filter();
      node.accept(8'hA5);
      rdb(ra0, 8'hA5);
      node.accept(8'h02);
      wrb(ra0, 8'h00);
      rdb(ra0, 8'hA7);
      rdb(ra2, 8'h00);
   endtask
   task automatic t_midreset();
      @(posedge clk) resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rdb(ra0, 8'h00);
      chk("dispatch_on", 0, {31'd0, on});
      @(posedge clk) silent <= 1'b1;
      for (int i = 0; i < 4; i++) rdb(ra3 + 12'(i), 8'h00);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_locked();
      t_program();
      t_dispatch();
      t_filter();
      t_midreset();
      finish_test();
   end
endmodule
`default_nettype wire
